// ### rtl/ccc_defines.vh
`ifndef CCC_DEFINES_VH
`define CCC_DEFINES_VH

// register indices; byte address is four times the index
`define CCC_IDX_GAIN_HIGH   8'h20
`define CCC_IDX_GAIN_LOW    8'h21
`define CCC_IDX_CH5_CONFIG  8'h22
`define CCC_IDX_W           8

// apb address layout
`define CCC_ADDR_W          12
`define CCC_ADDR_IDX_MSB    9
`define CCC_ADDR_IDX_LSB    2
`define CCC_ADDR_ALIGN      2'h0

// gain lower register field
`define CCC_GLOW_MSB        15
`define CCC_GLOW_LSB        8

// channel-5 configuration fields
`define CCC_PHASE_MSB       15
`define CCC_PHASE_LSB       6
`define CCC_DCOFF_BIT       2
`define CCC_MUX_MSB         1
`define CCC_MUX_LSB         0
`define CCC_CFG_W           13
`define CCC_STORE_PHASE_MSB 12
`define CCC_STORE_PHASE_LSB 3
`define CCC_STORE_DCOFF_BIT 2
`define CCC_STORE_MUX_MSB   1
`define CCC_STORE_MUX_LSB   0

// reset values
`define CCC_GHIGH_RST       16'h8000
`define CCC_GLOW_RST        8'h00
`define CCC_CFG_RST         13'h0000
`define CCC_DATA_ZERO       32'h00000000

// input select codes
`define CCC_MUX_PINS        2'h0
`define CCC_MUX_SHORT       2'h1
`define CCC_MUX_TEST_POS    2'h2
`define CCC_MUX_TEST_NEG    2'h3

// gain arithmetic: one lsb is 2 / 2^24, so unity is 2^23
`define CCC_GAIN_W          24
`define CCC_GAIN_FRAC       23
`define CCC_PROD_MSB        47
`define CCC_SAMPLE_MAX      24'h7FFFFF
`define CCC_SAMPLE_MIN      24'h800000
`define CCC_DC_OFF          4'h0

`endif

// ### rtl/ccc_field.v
`timescale 1ns/1ps

// one read-write register field with its own reset value
module ccc_field #(
  parameter                 WIDTH    = 8,
  parameter [WIDTH-1:0]     RESETVAL = {WIDTH{1'b0}}
) (
  input  wire               clk,        // device clock
  input  wire               rst_n,      // synchronous reset, active low
  input  wire               writeEn,    // one-cycle write strobe
  input  wire [WIDTH-1:0]   writeData,  // new field value
  output reg  [WIDTH-1:0]   value       // stored field value
);

  // store on write, reload reset value under reset
  always @(posedge clk) begin
    if (!rst_n) begin
      value <= RESETVAL;
    end else if (writeEn) begin
      value <= writeData;
    end
  end

endmodule // ccc_field

// ### rtl/ccc_regs.v
// Notes on behaviour
// - gain upper register holds gain bits 23:8 in all 16 bits, read-write.
// - gain lower register holds gain bits 7:0 in bits 15:8, read-write.
// - assembled 24-bit gain is unsigned multiplier, 0 to just under 2.
// - channel-5 bits 15:6 hold signed phase delay in modulator clock cycles.
// - filter-off bit 2 clear (reset) lets channel 5 follow global setting.
// - filter-off bit set bypasses channel-5 dc filter regardless of global.
// - select 00 routes own input pair (reset); 01 shorts converter inputs.
// - select 10 gives positive dc test signal; 11 gives negative one.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "ccc_defines.vh"

module ccc_regs (
  input  wire                     clk,             // device clock, 100 MHz
  input  wire                     rst_n,           // synchronous reset, active low
  input  wire [`CCC_ADDR_W-1:0]   paddr,           // apb byte address
  input  wire                     psel,            // apb select
  input  wire                     penable,         // apb access phase
  input  wire                     pwrite,          // apb direction, high for write
  input  wire [31:0]              pwdata,          // apb write data
  input  wire [3:0]               pstrb,           // apb byte strobes
  output reg  [31:0]              prdata,          // apb read data
  output reg                      pready,          // apb ready
  output reg                      pslverr,         // apb error, unmapped address
  input  wire [3:0]               globalDcFilterSetting, // global dc filter setting
  input  wire [`CCC_GAIN_W-1:0]   ch4SampleIn,     // channel-4 signed sample
  output reg  [`CCC_GAIN_W-1:0]   ch4SampleScaled, // channel-4 sample times gain
  output reg  [`CCC_GAIN_W-1:0]   ch4GainCal,      // assembled gain word
  output reg  [9:0]               ch5PhaseDelay,   // signed phase delay
  output reg  [3:0]               ch5DcFilterSetting, // effective dc setting
  output reg                      ch5DcFilterBypass,  // dc filter bypassed
  output reg  [1:0]               ch5InputSelect,  // raw input select
  output reg                      ch5RoutePins,    // own input pair routed
  output reg                      ch5ShortInputs,  // converter inputs shorted
  output reg                      ch5TestPos,      // positive dc test signal
  output reg                      ch5TestNeg       // negative dc test signal
);

  // stored fields
  wire [15:0]                     gainHigh;        // gain bits 23:8
  wire [7:0]                      gainLow;         // gain bits 7:0
  wire [`CCC_CFG_W-1:0]           ch5Config;       // phase, filter-off, select

  // decode and access qualifiers
  wire [`CCC_IDX_W-1:0]           regIndex;
  wire                            aligned;
  reg                             hitGainHigh;
  reg                             hitGainLow;
  reg                             hitCh5Config;
  reg                             mapped;
  wire                            accessDone;
  wire                            accessWait;
  wire                            writeOk;
  wire                            wrGainHigh;
  wire                            wrGainLow;
  wire                            wrCh5Config;

  // write data with byte strobes merged over current contents
  reg  [15:0]                     mergedHigh;
  reg  [15:0]                     mergedLow;
  reg  [15:0]                     mergedCfg;
  reg  [31:0]                     readValue;

  // next values of the bus answer
  reg                             next_pready;
  reg  [31:0]                     next_prdata;
  reg                             next_pslverr;

  // gain arithmetic
  wire [`CCC_GAIN_W-1:0]          gainWord;
  wire signed [`CCC_GAIN_W:0]     gainSigned;
  wire signed [`CCC_GAIN_W-1:0]   sampleSigned;
  wire signed [48:0]              product;
  wire signed [24:0]              scaledWide;
  reg  [`CCC_GAIN_W-1:0]          next_scaled;

  // channel-5 decoded controls
  wire [9:0]                      phaseField;
  wire                            dcOffField;
  wire [1:0]                      muxField;

  // register index and alignment of the byte address
  assign regIndex = paddr[`CCC_ADDR_IDX_MSB:`CCC_ADDR_IDX_LSB];
  assign aligned  = (paddr[1:0] == `CCC_ADDR_ALIGN) &&
                    (paddr[`CCC_ADDR_W-1:`CCC_ADDR_IDX_MSB+1] == 2'h0);

  // address decode
  always @* begin
    hitGainHigh = 1'b0;
    hitGainLow  = 1'b0;
    hitCh5Config = 1'b0;
    if (!aligned) begin
      hitGainHigh = 1'b0;
    end else if (regIndex == `CCC_IDX_GAIN_HIGH) begin
      hitGainHigh = 1'b1;
    end else if (regIndex == `CCC_IDX_GAIN_LOW) begin
      hitGainLow = 1'b1;
    end else if (regIndex == `CCC_IDX_CH5_CONFIG) begin
      hitCh5Config = 1'b1;
    end
    mapped = hitGainHigh | hitGainLow | hitCh5Config;
  end

  // one wait state: ready rises in the second access cycle
  assign accessWait = psel & penable & ~pready;
  assign accessDone = psel & penable & pready;
  assign writeOk    = accessDone & pwrite & mapped;
  assign wrGainHigh = writeOk & hitGainHigh;
  assign wrGainLow  = writeOk & hitGainLow;
  assign wrCh5Config = writeOk & hitCh5Config;

  // read image of each register
  always @* begin
    readValue = `CCC_DATA_ZERO;
    if (hitGainHigh) begin
      readValue[15:0] = gainHigh;
    end else if (hitGainLow) begin
      readValue[`CCC_GLOW_MSB:`CCC_GLOW_LSB] = gainLow;
      readValue[`CCC_GLOW_LSB-1:0] = 8'h00;
    end else if (hitCh5Config) begin
      readValue[`CCC_PHASE_MSB:`CCC_PHASE_LSB] = phaseField;
      readValue[`CCC_DCOFF_BIT] = dcOffField;
      readValue[`CCC_MUX_MSB:`CCC_MUX_LSB] = muxField;
      readValue[`CCC_PHASE_LSB-1:`CCC_DCOFF_BIT+1] = 3'h0;
    end
  end

  // byte-strobe merge; reserved bits never reach storage
  always @* begin
    mergedHigh = gainHigh;
    mergedLow  = {gainLow, 8'h00};
    mergedCfg  = {phaseField, 3'h0, dcOffField, muxField};
    if (pstrb[0]) begin
      mergedHigh[7:0] = pwdata[7:0];
      mergedCfg[7:0]  = pwdata[7:0];
    end
    if (pstrb[1]) begin
      mergedHigh[15:8] = pwdata[15:8];
      mergedLow[15:8]  = pwdata[15:8];
      mergedCfg[15:8]  = pwdata[15:8];
    end
  end

  ccc_field #(
    .WIDTH    (16),
    .RESETVAL (`CCC_GHIGH_RST)
  ) uGainHigh (
    .clk       (clk),
    .rst_n     (rst_n),
    .writeEn   (wrGainHigh),
    .writeData (mergedHigh),
    .value     (gainHigh)
  );

  // lower gain storage, low byte dropped
  ccc_field #(
    .WIDTH    (8),
    .RESETVAL (`CCC_GLOW_RST)
  ) uGainLow (
    .clk       (clk),
    .rst_n     (rst_n),
    .writeEn   (wrGainLow),
    .writeData (mergedLow[`CCC_GLOW_MSB:`CCC_GLOW_LSB]),
    .value     (gainLow)
  );

  // bits 5:3 left out of channel-5 storage
  ccc_field #(
    .WIDTH    (`CCC_CFG_W),
    .RESETVAL (`CCC_CFG_RST)
  ) uCh5Config (
    .clk       (clk),
    .rst_n     (rst_n),
    .writeEn   (wrCh5Config),
    .writeData ({mergedCfg[`CCC_PHASE_MSB:`CCC_PHASE_LSB],
                 mergedCfg[`CCC_DCOFF_BIT],
                 mergedCfg[`CCC_MUX_MSB:`CCC_MUX_LSB]}),
    .value     (ch5Config)
  );

  // stored channel-5 fields, reserved bits already squeezed out
  assign phaseField = ch5Config[`CCC_STORE_PHASE_MSB:`CCC_STORE_PHASE_LSB];
  assign dcOffField = ch5Config[`CCC_STORE_DCOFF_BIT];
  assign muxField   = ch5Config[`CCC_STORE_MUX_MSB:`CCC_STORE_MUX_LSB];

  // bus answer for the cycle after this one
  always @* begin
    next_pready  = accessWait;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (accessWait) begin
      next_pslverr = ~mapped;
      if (!pwrite && mapped) begin
        next_prdata = readValue;
      end else begin
        next_prdata = `CCC_DATA_ZERO;
      end
    end
  end

  // bus answer registers
  always @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= `CCC_DATA_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // unsigned gain against signed sample, unity at 2^23
  assign gainWord     = {gainHigh, gainLow};
  assign gainSigned   = $signed({1'b0, gainWord});
  assign sampleSigned = $signed(ch4SampleIn);
  assign product      = sampleSigned * gainSigned;
  assign scaledWide   = product[`CCC_PROD_MSB:`CCC_GAIN_FRAC];

  // saturate the scaled sample to 24 bits
  always @* begin
    if (scaledWide > $signed({1'b0, `CCC_SAMPLE_MAX})) begin
      next_scaled = `CCC_SAMPLE_MAX;
    end else if (scaledWide < $signed({1'b1, `CCC_SAMPLE_MIN})) begin
      next_scaled = `CCC_SAMPLE_MIN;
    end else begin
      next_scaled = scaledWide[`CCC_GAIN_W-1:0];
    end
  end

  // channel-4 assembled gain word, mixed while halves are rewritten
  always @(posedge clk) begin
    if (!rst_n) begin
      ch4GainCal <= {`CCC_GHIGH_RST, `CCC_GLOW_RST};
    end else begin
      ch4GainCal <= gainWord;
    end
  end

  // channel-4 scaled sample, one cycle behind the input
  always @(posedge clk) begin
    if (!rst_n) begin
      ch4SampleScaled <= {`CCC_GAIN_W{1'b0}};
    end else begin
      ch4SampleScaled <= next_scaled;
    end
  end

  // channel-5 phase delay
  always @(posedge clk) begin
    if (!rst_n) begin
      ch5PhaseDelay <= 10'h000;
    end else begin
      ch5PhaseDelay <= phaseField;
    end
  end

  // channel-5 dc filter control
  always @(posedge clk) begin
    if (!rst_n) begin
      ch5DcFilterSetting <= `CCC_DC_OFF;
      ch5DcFilterBypass  <= 1'b0;
    end else begin
      if (dcOffField) begin
        ch5DcFilterSetting <= `CCC_DC_OFF;
        ch5DcFilterBypass  <= 1'b1;
      end else begin
        ch5DcFilterSetting <= globalDcFilterSetting;
        ch5DcFilterBypass  <= (globalDcFilterSetting == `CCC_DC_OFF);
      end
    end
  end

  // channel-5 raw input select
  always @(posedge clk) begin
    if (!rst_n) begin
      ch5InputSelect <= `CCC_MUX_PINS;
    end else begin
      ch5InputSelect <= muxField;
    end
  end

  // channel-5 input routing, one-hot
  always @(posedge clk) begin
    if (!rst_n) begin
      ch5RoutePins   <= 1'b1;
      ch5ShortInputs <= 1'b0;
      ch5TestPos     <= 1'b0;
      ch5TestNeg     <= 1'b0;
    end else begin
      ch5RoutePins   <= (muxField == `CCC_MUX_PINS);
      ch5ShortInputs <= (muxField == `CCC_MUX_SHORT);
      ch5TestPos     <= (muxField == `CCC_MUX_TEST_POS);
      ch5TestNeg     <= (muxField == `CCC_MUX_TEST_NEG);
    end
  end

endmodule // ccc_regs

// ### testbench/ccc_regs_properties.sv
`timescale 1ns/1ps
// port-level checks of the register block
module ccc_regs_properties (
  input logic        clk,                   // device clock
  input logic        rst_n,                 // synchronous reset, active low
  input logic        psel,                  // apb select
  input logic        penable,               // apb access phase
  input logic        pwrite,                // apb direction
  input logic [31:0] prdata,                // apb read data
  input logic        pready,                // apb ready
  input logic        pslverr,               // apb error
  input logic [3:0]  globalDcFilterSetting, // global dc filter setting
  input logic [23:0] ch4SampleIn,           // channel-4 sample
  input logic [23:0] ch4SampleScaled,       // scaled sample
  input logic [23:0] ch4GainCal,            // assembled gain
  input logic [3:0]  ch5DcFilterSetting,    // effective dc setting
  input logic        ch5DcFilterBypass,     // dc filter bypassed
  input logic [1:0]  ch5InputSelect,        // raw input select
  input logic        ch5RoutePins,          // own pair routed
  input logic        ch5ShortInputs,        // inputs shorted
  input logic        ch5TestPos,            // positive test signal
  input logic        ch5TestNeg             // negative test signal
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // setup cycle followed by exactly one wait cycle
  sequence s_setup; psel && !penable; endsequence
  sequence s_wait_done; psel && penable && !pready ##1 pready; endsequence
  a_one_wait: assert property (s_setup |=> s_wait_done) else $error("ready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_follow_global: assert property (
    $past(rst_n) && !ch5DcFilterBypass |-> ch5DcFilterSetting == $past(globalDcFilterSetting))
    else $error("dc setting not following global");
  a_bypass_zero: assert property (ch5DcFilterBypass |-> ch5DcFilterSetting == 4'h0)
    else $error("bypass with nonzero dc setting");
  a_select_onehot: assert property (
    {ch5TestNeg, ch5TestPos, ch5ShortInputs, ch5RoutePins} == (4'h1 << ch5InputSelect))
    else $error("input select decode wrong");
  a_unity_gain: assert property (
    $past(rst_n) && ch4GainCal == 24'h800000 && $past(ch4GainCal) == 24'h800000
    |-> ch4SampleScaled == $past(ch4SampleIn)) else $error("unity gain changed sample");
  a_zero_gain: assert property (
    $past(rst_n) && ch4GainCal == 24'h000000 && $past(ch4GainCal) == 24'h000000
    |-> ch4SampleScaled == 24'h000000) else $error("zero gain gave nonzero sample");
endmodule // ccc_regs_properties

bind ccc_regs ccc_regs_properties i_props (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .globalDcFilterSetting(globalDcFilterSetting), .ch4SampleIn(ch4SampleIn),
  .ch4SampleScaled(ch4SampleScaled), .ch4GainCal(ch4GainCal),
  .ch5DcFilterSetting(ch5DcFilterSetting), .ch5DcFilterBypass(ch5DcFilterBypass),
  .ch5InputSelect(ch5InputSelect), .ch5RoutePins(ch5RoutePins),
  .ch5ShortInputs(ch5ShortInputs), .ch5TestPos(ch5TestPos), .ch5TestNeg(ch5TestNeg));

// ### testbench/channel_cal_config_regs_bench.sv
`timescale 1ns/1ps
// drives the register block over apb and checks reads and outputs
module channel_cal_config_regs_bench;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, rdErr;
  logic        ch5DcFilterBypass, ch5RoutePins, ch5ShortInputs, ch5TestPos, ch5TestNeg;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [3:0]  pstrb, globalDcFilterSetting, ch5DcFilterSetting;
  logic [23:0] ch4SampleIn, ch4SampleScaled, ch4GainCal;
  logic [9:0]  ch5PhaseDelay;
  logic [1:0]  ch5InputSelect;
  int          errors, checkCount;
  localparam logic [11:0] A_HIGH = 12'h080, A_LOW = 12'h084, A_CFG = 12'h088;

  ccc_regs i_dut (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .globalDcFilterSetting(globalDcFilterSetting),
    .ch4SampleIn(ch4SampleIn), .ch4SampleScaled(ch4SampleScaled), .ch4GainCal(ch4GainCal),
    .ch5PhaseDelay(ch5PhaseDelay), .ch5DcFilterSetting(ch5DcFilterSetting),
    .ch5DcFilterBypass(ch5DcFilterBypass), .ch5InputSelect(ch5InputSelect),
    .ch5RoutePins(ch5RoutePins), .ch5ShortInputs(ch5ShortInputs), .ch5TestPos(ch5TestPos),
    .ch5TestNeg(ch5TestNeg));

  // free-running device clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare one value and report a mismatch
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer, request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // wait for ready; only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
    apb(1'b0, a, 32'h00000000, 4'h0);
    chk("prdata", exp, rdData);
    chk("pslverr", {31'h00000000, expErr}, {31'h00000000, rdErr});
  endtask

  // full write, then let derived outputs settle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
    repeat (2) @(posedge clk);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    close_out;
  end

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    globalDcFilterSetting = 4'h5;
    ch4SampleIn = 24'h000000;
    errors = 0;
    checkCount = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(A_HIGH, 32'h00008000, 1'b0);
    rd(A_LOW, 32'h00000000, 1'b0);
    rd(A_CFG, 32'h00000000, 1'b0);
    chk("ch4GainCal", 32'h00800000, {8'h00, ch4GainCal});
    // halves written independently, reserved bits dropped
    wr(A_HIGH, 32'hFFFFA5C3);
    rd(A_HIGH, 32'h0000A5C3, 1'b0);
    wr(A_LOW, 32'h0000FFFF);
    rd(A_LOW, 32'h0000FF00, 1'b0);
    chk("ch4GainCal", 32'h00A5C3FF, {8'h00, ch4GainCal});
    apb(1'b1, A_HIGH, 32'h00001234, 4'h1);
    rd(A_HIGH, 32'h0000A534, 1'b0);
    // phase of minus one, filter forced off
    wr(A_CFG, 32'h0000FFFF);
    rd(A_CFG, 32'h0000FFC7, 1'b0);
    chk("ch5PhaseDelay", 32'h000003FF, {22'h000000, ch5PhaseDelay});
    chk("ch5DcFilterSetting", 32'h0, {28'h0, ch5DcFilterSetting});
    chk("ch5DcFilterBypass", 32'h1, {31'h0, ch5DcFilterBypass});
    // most negative phase step, filter follows global
    wr(A_CFG, 32'h00008000);
    chk("ch5PhaseDelay", 32'h00000200, {22'h000000, ch5PhaseDelay});
    chk("ch5DcFilterSetting", 32'h5, {28'h0, ch5DcFilterSetting});
    globalDcFilterSetting <= 4'hA;
    repeat (2) @(posedge clk);
    chk("ch5DcFilterSetting", 32'hA, {28'h0, ch5DcFilterSetting});
    chk("ch5DcFilterBypass", 32'h0, {31'h0, ch5DcFilterBypass});
    // every input select code
    for (int i = 0; i < 4; i++) begin
      wr(A_CFG, i);
      chk("select", {4'h1 << i}, {ch5TestNeg, ch5TestPos, ch5ShortInputs, ch5RoutePins});
      chk("ch5InputSelect", i, {30'h0, ch5InputSelect});
    end
    // gain: unity, half, just under two, saturation, zero
    ch4SampleIn <= 24'h123456;
    wr(A_HIGH, 32'h00008000);
    wr(A_LOW, 32'h00000000);
    chk("scaled", 32'h00123456, {8'h00, ch4SampleScaled});
    wr(A_HIGH, 32'h00004000);
    chk("scaled", 32'h00091A2B, {8'h00, ch4SampleScaled});
    wr(A_HIGH, 32'h0000FFFF);
    wr(A_LOW, 32'h0000FF00);
    chk("scaled", 32'h002468AB, {8'h00, ch4SampleScaled});
    ch4SampleIn <= 24'h500000;
    repeat (2) @(posedge clk);
    chk("scaled", 32'h007FFFFF, {8'h00, ch4SampleScaled});
    ch4SampleIn <= 24'hB00000;
    repeat (2) @(posedge clk);
    chk("scaled", 32'h00800000, {8'h00, ch4SampleScaled});
    wr(A_HIGH, 32'h00000000);
    wr(A_LOW, 32'h00000000);
    chk("scaled", 32'h00000000, {8'h00, ch4SampleScaled});
    // unmapped, misaligned and aliased addresses are refused
    rd(12'h08C, 32'h00000000, 1'b1);
    apb(1'b1, 12'h081, 32'h0000FFFF, 4'hF);
    chk("pslverr", 32'h1, {31'h0, rdErr});
    apb(1'b1, 12'h480, 32'h00001111, 4'hF);
    chk("pslverr", 32'h1, {31'h0, rdErr});
    rd(A_HIGH, 32'h00000000, 1'b0);
    close_out;
  end
endmodule // channel_cal_config_regs_bench
